// [pkg/sar_readout_pkg.sv]
// Constants and types for the serial readout of the SAR converter core.
// Assumes one system clock; the host model paces the pin timing in cycles of it but checks none of it.
package sar_readout_pkg;

  // Resolution of the variant, in bits
  localparam int RESOLUTION_DEFAULT = 12;
  localparam int RESOLUTION_MIN = 2;
  localparam int RESOLUTION_MAX = 16;

  // Pacing clock falls after select low at which hold and the null bit begin
  localparam int HOLD_FALL_INDEX = 2;

  // System clock period and host-side pacing limits, for reference by checks
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int PACING_MIN_KHZ = 10;
  localparam int PACING_MAX_KHZ_12BIT = 2000;
  localparam int PACING_MAX_KHZ_10BIT = 2800;
  localparam int PACING_MAX_KHZ_8BIT = 3000;
  localparam int PACING_PHASE_MIN_NS = 400;
  localparam int PACING_PHASE_MIN_CYCLES =
    (PACING_PHASE_MIN_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // Sequencing states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_TRACK   = 3'b001,
    ST_CONVERT = 3'b010,
    ST_REPEAT  = 3'b011,
    ST_ZEROS   = 3'b100
  } seq_state_type;

endpackage

// [hw/sar_adc_serial_readout.sv]
// SAR converter sequencer and serial result readout.
// Assumes the pacing clock, select and comparator arrive asynchronously and
// the pacing clock is far slower than the system clock.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout
  import sar_readout_pkg::*;
#(
  parameter int RESOLUTION = RESOLUTION_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic select_and_shutdown_n_in,
  input wire logic serial_pacing_clock_in,
  input wire logic comparator_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  output logic sample_track_out,
  output logic inputs_isolated_out,
  output logic neg_input_hold_out,
  output logic powered_out,
  output logic [RESOLUTION-1:0] dac_trial_out
);

  localparam int IW = (RESOLUTION > 1) ? $clog2(RESOLUTION) : 1;
  localparam logic [IW-1:0] IDX_TOP = IW'(RESOLUTION - 1);
  localparam logic [IW-1:0] IDX_ONE = IW'(1);

  // Refuse resolutions the index and counter logic cannot serve
  if (RESOLUTION < RESOLUTION_MIN || RESOLUTION > RESOLUTION_MAX) begin : g_chk
    $error("RESOLUTION out of supported range");
  end

  // Two-flop synchronisers; the third dclk stage is only for edge detection
  logic cs_m_q, cs_s_q;
  logic dclk_m_q, dclk_s_q, dclk_p_q;
  logic comp_m_q, comp_s_q;
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      cs_m_q <= 1'b1;
      cs_s_q <= 1'b1;
      dclk_m_q <= 1'b0;
      dclk_s_q <= 1'b0;
      dclk_p_q <= 1'b0;
      comp_m_q <= 1'b0;
      comp_s_q <= 1'b0;
    end else begin
      cs_m_q <= select_and_shutdown_n_in;
      cs_s_q <= cs_m_q;
      dclk_m_q <= serial_pacing_clock_in;
      dclk_s_q <= dclk_m_q;
      dclk_p_q <= dclk_s_q;
      comp_m_q <= comparator_in;
      comp_s_q <= comp_m_q;
    end
  end

  logic fall;
  logic cs_hi;
  assign fall = dclk_p_q & ~dclk_s_q;
  assign cs_hi = cs_s_q;

  seq_state_type state_q, state_d;
  logic [1:0] fall_cnt_q, fall_cnt_d;
  logic [IW-1:0] idx_q, idx_d;
  logic [RESOLUTION-1:0] sar_q, sar_d;
  logic dout_q, dout_d;
  logic oe_q, oe_d;
  logic neg_q, neg_d;

  // Next-state logic; after the idle-to-track step, only pacing clock falls advance the sequence
  always_comb begin
    state_d = state_q;
    fall_cnt_d = fall_cnt_q;
    idx_d = idx_q;
    sar_d = sar_q;
    dout_d = dout_q;
    oe_d = oe_q;
    neg_d = 1'b0;
    if (cs_hi) begin
      // Deselect resets sequencing and floats the output
      state_d = ST_IDLE;
      fall_cnt_d = 2'd0;
      idx_d = IDX_TOP;
      sar_d = '0;
      dout_d = 1'b0;
      oe_d = 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_d = ST_TRACK;
        end
        ST_TRACK: begin
          if (fall) begin
            fall_cnt_d = fall_cnt_q + 2'd1;
            if (fall_cnt_d == 2'(HOLD_FALL_INDEX)) begin
              // Enter hold: freeze the sample, drive the null bit
              state_d = ST_CONVERT;
              neg_d = 1'b1;
              oe_d = 1'b1;
              dout_d = 1'b0;
              sar_d = '0;
              sar_d[IDX_TOP] = 1'b1;
              idx_d = IDX_TOP;
            end
          end
        end
        ST_CONVERT: begin
          if (fall) begin
            // Decided bit goes straight out, so no pipeline delay
            sar_d[idx_q] = comp_s_q;
            dout_d = comp_s_q;
            if (idx_q == '0) begin
              state_d = (RESOLUTION > 1) ? ST_REPEAT : ST_ZEROS;
              idx_d = IDX_ONE;
            end else begin
              sar_d[idx_q - IDX_ONE] = 1'b1;
              idx_d = idx_q - IDX_ONE;
            end
          end
        end
        ST_REPEAT: begin
          if (fall) begin
            // LSB is shared, so the replay starts at bit one
            dout_d = sar_q[idx_q];
            if (idx_q == IDX_TOP) begin
              state_d = ST_ZEROS;
            end else begin
              idx_d = idx_q + IDX_ONE;
            end
          end
        end
        ST_ZEROS: begin
          if (fall) begin
            dout_d = 1'b0;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      state_q <= ST_IDLE;
      fall_cnt_q <= 2'd0;
      idx_q <= IDX_TOP;
      sar_q <= '0;
      dout_q <= 1'b0;
      oe_q <= 1'b0;
      neg_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fall_cnt_q <= fall_cnt_d;
      idx_q <= idx_d;
      sar_q <= sar_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      neg_q <= neg_d;
    end
  end

  // Analog control; DAC weight per code is reference over two to N
  assign serial_data_out = dout_q;
  assign serial_data_oe_out = oe_q;
  assign sample_track_out = (state_q == ST_TRACK);
  assign inputs_isolated_out = (state_q != ST_TRACK);
  assign neg_input_hold_out = neg_q;
  assign powered_out = ~cs_hi;
  assign dac_trial_out = sar_q;

  chk_null_bit_low: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in) $rose(oe_q) |-> !dout_q && $past(fall))
    else $error("null bit not low on enable");

  chk_float_on_deselect: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in) cs_hi |=> !oe_q && state_q == ST_IDLE)
    else $error("output not floated on deselect");

  chk_msb_first_out: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    state_q == ST_CONVERT && fall && idx_q == IDX_TOP && !cs_hi
    |=> dout_q == $past(comp_s_q) && sar_q[IDX_TOP] == dout_q)
    else $error("MSB not sent first");

  chk_launch_on_fall: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    $changed(dout_q) && !$past(cs_hi) |-> $past(fall))
    else $error("data changed off a pacing fall");

  chk_isolate_convert: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    (state_q == ST_CONVERT || oe_q)
    |-> inputs_isolated_out && !sample_track_out)
    else $error("inputs not isolated in conversion");

  // Enable and state are separate flops, so this is not true by construction
  chk_hold_ends_track: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    neg_q |-> $past(sample_track_out) && inputs_isolated_out && oe_q)
    else $error("hold entry did not end tracking");

  chk_neg_sample_once: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    neg_q |-> $past(state_q) == ST_TRACK && state_q == ST_CONVERT)
    else $error("negative input sampled outside hold start");

  chk_zeros_tail: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    state_q == ST_ZEROS && fall && !cs_hi |=> !dout_q && oe_q)
    else $error("tail not zero");

  chk_no_restart: assert property (@(posedge clk_sys_in)
    disable iff (!resetn_in)
    state_q != ST_IDLE && state_q != ST_TRACK && !cs_hi
    |=> state_q != ST_TRACK)
    else $error("restart without select toggle");

endmodule // sar_adc_serial_readout
`default_nettype wire

// [verification/host_pacer_model.sv]
// Host model: frames select low and paces the data clock, capturing bits.
// Assumes clk_in is the system clock; the pacing clock rests low between frames.
`timescale 1ns/1ps
`default_nettype none
module host_pacer_model
  import sar_readout_pkg::*;
#(
  parameter int HALF = PACING_PHASE_MIN_CYCLES
) (
  input wire logic clk_in,
  input wire logic start_in,
  input wire logic [5:0] falls_in,
  input wire logic data_in,
  input wire logic oe_in,
  output logic select_n_out,
  output logic pacing_clk_out,
  output logic busy_out,
  output logic [47:0] cap_out,
  output logic [5:0] cap_count_out
);
  // Each phase lasts HALF cycles, inside the allowed rate and phase widths
  initial begin
    select_n_out = 1'b1;
    pacing_clk_out = 1'b0;
    busy_out = 1'b0;
    cap_out = '0;
    cap_count_out = '0;
    forever begin
      @(posedge clk_in);
      if (start_in) begin
        busy_out <= 1'b1;
        cap_out <= '0;
        cap_count_out <= '0;
        select_n_out <= 1'b0;
        repeat (falls_in) begin
          repeat (HALF) @(posedge clk_in);
          pacing_clk_out <= 1'b1;
          // Bits are taken on the rising edge, only while driven
          if (oe_in === 1'b1) begin
            cap_out <= {cap_out[46:0], data_in};
            cap_count_out <= cap_count_out + 6'h01;
          end
          repeat (HALF) @(posedge clk_in);
          pacing_clk_out <= 1'b0;
        end
        repeat (HALF) @(posedge clk_in);
        select_n_out <= 1'b1;
        repeat (HALF) @(posedge clk_in);
        busy_out <= 1'b0;
      end
    end
  end
endmodule // host_pacer_model
`default_nettype wire

// [verification/sar_adc_serial_readout_tb.sv]
// Testbench for the serial readout: frames, replay, abort and restart.
// Assumes the host model and an ideal comparator on the trial code.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_serial_readout_tb;
  import sar_readout_pkg::*;
  localparam int N = 8;
  logic clk = 1'b0, rst_n = 1'b0, start_q = 1'b0, sel_n, pclk, busy;
  logic data, oe, track, iso, neg, pwr;
  logic [N-1:0] dac, analog_q = '0;
  logic [5:0] falls_q = '0, cap_n;
  logic [47:0] cap;
  int fails = 0, compares = 0, negs, tracks, isos, lates, since;
  logic pclk_p, data_p;
  // Ideal comparator: keeps a trial bit while the input is at or above it
  wire logic cmp = (analog_q >= dac);
  sar_adc_serial_readout #(.RESOLUTION(N)) sar_adc_serial_readout_i (
    .clk_sys_in(clk), .resetn_in(rst_n), .select_and_shutdown_n_in(sel_n),
    .serial_pacing_clock_in(pclk), .comparator_in(cmp),
    .serial_data_out(data), .serial_data_oe_out(oe),
    .sample_track_out(track), .inputs_isolated_out(iso),
    .neg_input_hold_out(neg), .powered_out(pwr), .dac_trial_out(dac));
  host_pacer_model host_pacer_model_i (
    .clk_in(clk), .start_in(start_q), .falls_in(falls_q), .data_in(data),
    .oe_in(oe), .select_n_out(sel_n), .pacing_clk_out(pclk),
    .busy_out(busy), .cap_out(cap), .cap_count_out(cap_n));
  initial begin
    forever #2 clk = ~clk;
  end
  // Frame monitors; late data changes would mean bits not paced by falls
  always @(posedge clk) begin
    pclk_p <= pclk;
    data_p <= data;
    since <= (pclk_p && !pclk) ? 0 : since + 1;
    if (neg === 1'b1) negs++;
    if (track === 1'b1) tracks++;
    if (oe === 1'b1 && (track !== 1'b0 || iso !== 1'b1)) isos++;
    if (!sel_n && oe && data !== data_p && since > 8) lates++;
  end
  task automatic compare(input string what, input logic [47:0] e, g);
    compares++;
    if (e !== g) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Expected capture: null bit, MSB first, replay from bit 1, then zeros
  function automatic logic [47:0] stream(logic [N-1:0] v, int f);
    logic [47:0] s = '0;
    for (int p = 0; p <= f - 3; p++)
      s = {s[46:0], (p >= 1 && p <= N) ? v[N-p] :
           (p > N && p < 2*N) ? v[p-N] : 1'b0};
    return s;
  endfunction
  task automatic frame(input logic [N-1:0] v, input int f);
    analog_q <= v;
    falls_q <= 6'(f);
    start_q <= 1'b1;
    @(posedge clk);
    start_q <= 1'b0;
    negs = 0; tracks = 0; isos = 0; lates = 0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 20000 && busy; i++) @(posedge clk);
    compare("busy", 48'h0, 48'(busy));
    compare("stream", stream(v, f), cap);
    compare("bits", 48'(f - 2), 48'(cap_n));
    compare("late", '0, 48'(lates));
    if (f > 2) compare("negs", 48'h1, 48'(negs));
    compare("track", 48'(1), 48'(tracks > 0));
    compare("iso", '0, 48'(isos));
    compare("idle", 48'h0, 48'({dac, oe, pwr}));
  endtask
  // Full frame: null bit, MSB-first result, LSB-first replay, zero tail
  task automatic test_replay_tail;
    frame(8'hA5, 2*N + 4);
  endtask
  // Second conversion right after the first must carry its own value
  task automatic test_back_to_back;
    frame(8'h3C, 2*N + 4);
  endtask
  // Select rises mid-result; the sequencer must drop back to idle
  task automatic test_abort_mid;
    frame(8'hFF, 6);
  endtask
  // A clean frame after the abort shows nothing carried over
  task automatic test_restart_after_abort;
    frame(8'h5A, 2*N + 4);
  endtask
  task automatic test_done;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    test_done;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    test_replay_tail();
    test_back_to_back();
    test_abort_mid();
    test_restart_after_abort();
    test_done;
  end
endmodule // sar_adc_serial_readout_tb
`default_nettype wire
